/* core/adc_cfg_pkg.sv */
// constants shared by the serial register write decoder
package adc_cfg_pkg;

   // ---------------------------------------------------------------
   // serial frame layout
   // ---------------------------------------------------------------
   localparam int unsigned FRAME_BITS = 16;
   localparam int unsigned COUNT_W    = 4;
   localparam logic [3:0]  LAST_BIT   = 4'hF;
   localparam logic [3:0]  FIRST_BIT  = 4'h0;

   // header position and codes: write flag, upper select, lower select
   localparam int unsigned HDR_MSB   = 15;
   localparam int unsigned HDR_LSB   = 13;
   localparam logic [2:0]  HDR_CTRL  = 3'h4;
   localparam logic [2:0]  HDR_RANGE = 3'h5;
   localparam logic [2:0]  HDR_SEQ   = 3'h7;

   // ---------------------------------------------------------------
   // register widths and where their bits sit in the frame
   // ---------------------------------------------------------------
   localparam int unsigned CTRL_W    = 12;
   localparam int unsigned CTRL_MSB  = 12;
   localparam int unsigned CTRL_LSB  = 1;
   localparam int unsigned RANGE_W   = 8;
   localparam int unsigned RANGE_MSB = 12;
   localparam int unsigned RANGE_LSB = 5;
   localparam int unsigned SEQ_W     = 4;
   localparam int unsigned SEQ_MSB   = 12;
   localparam int unsigned SEQ_LSB   = 9;

   // output coding bit inside the stored control word
   localparam int unsigned CODING_BIT = 4;

   // power-up values
   localparam logic [11:0] CTRL_RESET  = 12'h000;
   localparam logic [7:0]  RANGE_RESET = 8'h00;
   localparam logic [3:0]  SEQ_RESET   = 4'h0;

   // ---------------------------------------------------------------
   // conversion result
   // ---------------------------------------------------------------
   localparam int unsigned RESULT_W = 13;

endpackage

/* core/adc_serial_register_write_decoder.sv */
// serial frame decoder loading the three write-only config registers
//
// Summary of operation
// - every frame is sixteen serial clock cycles, decoded on that count.
// - the first three bits in are write flag, upper select, lower select.
// - write flag 1 loads the selected register, header 1,1,0 and write flag 0 load nothing.
// - header 1,0,0 loads the twelve following bits into conversion_control.
// - header 1,0,1 loads the eight following bits into input_span_select.
// - header 1,1,1 loads the four following bits into channel_sequence.
// - only these three registers exist and none can be read back on the link.
// - true differential results span codes -4096 to +4095 as signed values.
// - pseudo differential results give -4096 at pseudo ground, +4095 at top.
// - coding bit 0 gives twos complement, 1 straight binary, 0 after reset.
`timescale 1ns/1ns
module adc_serial_register_write_decoder #(
   parameter int unsigned RESULT_W = adc_cfg_pkg::RESULT_W
) (
   input  wire logic                sys_clk,
   input  wire logic                rst,
   // serial link, clocked by the host
   input  wire logic                sclk,
   input  wire logic                cs_n,
   input  wire logic                sdi,
   // conversion result from the converter core, twos complement
   input  wire logic [RESULT_W-1:0] conv_result,
   input  wire logic                conv_valid,
   // configuration seen by the converter
   output logic [11:0]              conversion_control,
   output logic [7:0]               input_span_select,
   output logic [3:0]               channel_sequence,
   output logic                     control_loaded,
   output logic                     range_loaded,
   output logic                     sequence_loaded,
   // coded result
   output logic [RESULT_W-1:0]      result_code,
   output logic                     result_valid
);

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   if (RESULT_W != adc_cfg_pkg::RESULT_W) begin : g_bad_width
      $error("result width must be thirteen bits");
   end

   // ---------------------------------------------------------------
   // link domain: bit counter and shift register
   // ---------------------------------------------------------------
   logic [adc_cfg_pkg::COUNT_W-1:0]    bit_count;
   logic [adc_cfg_pkg::COUNT_W-1:0]    next_bit_count;
   logic [adc_cfg_pkg::FRAME_BITS-2:0] shift_reg;
   logic [adc_cfg_pkg::FRAME_BITS-2:0] next_shift_reg;
   logic                               link_rst;

   // idle select clears the counter so an aborted frame starts clean
   assign link_rst = rst | cs_n;

   // shift in msb first and count sixteen edges
   always_comb begin
      next_shift_reg = {shift_reg[adc_cfg_pkg::FRAME_BITS-3:0], sdi};
      next_bit_count = bit_count + 4'h1;
   end

   always_ff @(posedge sclk or posedge link_rst) begin
      if (link_rst) begin
         bit_count <= adc_cfg_pkg::FIRST_BIT;
         shift_reg <= '0;
      end else begin
         bit_count <= next_bit_count;
         shift_reg <= next_shift_reg;
      end
   end

   // ---------------------------------------------------------------
   // link domain: frame capture and toggle towards system clock
   // ---------------------------------------------------------------
   logic [adc_cfg_pkg::FRAME_BITS-1:0] frame_hold;
   logic [adc_cfg_pkg::FRAME_BITS-1:0] next_frame_hold;
   logic                               frame_toggle;
   logic                               next_frame_toggle;
   logic                               frame_done;

   assign frame_done = (bit_count == adc_cfg_pkg::LAST_BIT);

   // whole word held stable until the next sixteenth edge
   always_comb begin
      next_frame_hold   = frame_hold;
      next_frame_toggle = frame_toggle;
      if (frame_done) begin
         next_frame_hold   = {shift_reg, sdi};
         next_frame_toggle = ~frame_toggle;
      end
   end

   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         frame_hold   <= '0;
         frame_toggle <= 1'b0;
      end else begin
         frame_hold   <= next_frame_hold;
         frame_toggle <= next_frame_toggle;
      end
   end

   // ---------------------------------------------------------------
   // crossing: toggle synchronised, word sampled after it settles
   // ---------------------------------------------------------------
   logic toggle_sync;
   logic toggle_seen;
   logic next_toggle_seen;
   logic frame_arrived;

   level_sync #(
      .WIDTH    (1)
   ) u_toggle_sync (
      .clk      (sys_clk),
      .rst      (rst),
      .async_in (frame_toggle),
      .sync_out (toggle_sync)
   );

   assign frame_arrived    = toggle_sync ^ toggle_seen;
   assign next_toggle_seen = toggle_sync;

   // ---------------------------------------------------------------
   // system domain: header decode and register loads
   // ---------------------------------------------------------------
   logic [2:0]  header;
   logic [11:0] next_conversion_control;
   logic [7:0]  next_input_span_select;
   logic [3:0]  next_channel_sequence;
   logic        next_control_loaded;
   logic        next_range_loaded;
   logic        next_sequence_loaded;

   assign header =
      frame_hold[adc_cfg_pkg::HDR_MSB:adc_cfg_pkg::HDR_LSB];

   // write-only targets: nothing here ever drives data back out
   always_comb begin
      next_conversion_control = conversion_control;
      next_input_span_select  = input_span_select;
      next_channel_sequence   = channel_sequence;
      next_control_loaded     = 1'b0;
      next_range_loaded       = 1'b0;
      next_sequence_loaded    = 1'b0;
      if (frame_arrived) begin
         case (header)
            adc_cfg_pkg::HDR_CTRL: begin
               next_conversion_control =
                  frame_hold[adc_cfg_pkg::CTRL_MSB:adc_cfg_pkg::CTRL_LSB];
               next_control_loaded = 1'b1;
            end
            adc_cfg_pkg::HDR_RANGE: begin
               next_input_span_select =
                  frame_hold[adc_cfg_pkg::RANGE_MSB:adc_cfg_pkg::RANGE_LSB];
               next_range_loaded = 1'b1;
            end
            adc_cfg_pkg::HDR_SEQ: begin
               next_channel_sequence =
                  frame_hold[adc_cfg_pkg::SEQ_MSB:adc_cfg_pkg::SEQ_LSB];
               next_sequence_loaded = 1'b1;
            end
            default: begin
               // write flag 0, or the unlisted 1,1,0 header
               next_control_loaded = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         toggle_seen        <= 1'b0;
         conversion_control <= adc_cfg_pkg::CTRL_RESET;
         input_span_select  <= adc_cfg_pkg::RANGE_RESET;
         channel_sequence   <= adc_cfg_pkg::SEQ_RESET;
         control_loaded     <= 1'b0;
         range_loaded       <= 1'b0;
         sequence_loaded    <= 1'b0;
      end else begin
         toggle_seen        <= next_toggle_seen;
         conversion_control <= next_conversion_control;
         input_span_select  <= next_input_span_select;
         channel_sequence   <= next_channel_sequence;
         control_loaded     <= next_control_loaded;
         range_loaded       <= next_range_loaded;
         sequence_loaded    <= next_sequence_loaded;
      end
   end

   // ---------------------------------------------------------------
   // system domain: result coding
   // ---------------------------------------------------------------
   logic [RESULT_W-1:0] next_result_code;
   logic                next_result_valid;
   logic                straight_binary;

   assign straight_binary = conversion_control[adc_cfg_pkg::CODING_BIT];

   // signed code -4096..+4095 passes as is, or gets offset by sign flip
   always_comb begin
      next_result_valid = conv_valid;
      next_result_code  = result_code;
      if (conv_valid) begin
         if (straight_binary) begin
            next_result_code = {~conv_result[RESULT_W-1],
                                conv_result[RESULT_W-2:0]};
         end else begin
            next_result_code = conv_result;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         result_code  <= '0;
         result_valid <= 1'b0;
      end else begin
         result_code  <= next_result_code;
         result_valid <= next_result_valid;
      end
   end

endmodule

/* core/level_sync.sv */
// two flip-flop synchroniser for slow levels
`timescale 1ns/1ns
module level_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta     <= '0;
         sync_out <= '0;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule

/* verification/adc_cfg_checker_assertions.sv */
// concurrent checks on the decoder ports
`timescale 1ns/1ns
module adc_cfg_checker #(
   parameter int unsigned RESULT_W = 13
) (
   input wire logic                sys_clk,
   input wire logic                rst,
   input wire logic [RESULT_W-1:0] conv_result,
   input wire logic                conv_valid,
   input wire logic [11:0]         conversion_control,
   input wire logic [7:0]          input_span_select,
   input wire logic [3:0]          channel_sequence,
   input wire logic                control_loaded,
   input wire logic                range_loaded,
   input wire logic                sequence_loaded,
   input wire logic [RESULT_W-1:0] result_code,
   input wire logic                result_valid
);
   logic [RESULT_W-1:0] coded;
   logic [2:0]          loads;
   // expected code and the three load pulses
   assign coded = {conv_result[RESULT_W-1] ^ conversion_control[4],
                   conv_result[RESULT_W-2:0]};
   assign loads = {control_loaded, range_loaded, sequence_loaded};
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   ctrl_change_a: assert property (
      $changed(conversion_control) |-> control_loaded) else $error("ctrl");
   range_change_a: assert property (
      $changed(input_span_select) |-> range_loaded) else $error("range");
   seq_change_a: assert property (
      $changed(channel_sequence) |-> sequence_loaded) else $error("seq");
   pulse_width_a: assert property (|loads |=> !(|loads))
      else $error("load pulse too long");
   one_target_a: assert property ($onehot0(loads))
      else $error("two loads at once");
   result_lat_a: assert property (conv_valid |=> result_valid)
      else $error("result late");
   result_src_a: assert property (result_valid |-> $past(conv_valid))
      else $error("stray result");
   code_map_a: assert property (
      conv_valid |=> result_code == $past(coded)) else $error("coding");
   reset_vals_a: assert property ($fell(rst) |->
      conversion_control == 12'h000 && input_span_select == 8'h00 &&
      channel_sequence == 4'h0) else $error("reset values");
   cover property (control_loaded);
   cover property (range_loaded);
   cover property (sequence_loaded);
endmodule
bind adc_serial_register_write_decoder adc_cfg_checker #(
   .RESULT_W(RESULT_W)) u_chk (.sys_clk(sys_clk), .rst(rst),
   .conv_result(conv_result), .conv_valid(conv_valid),
   .conversion_control(conversion_control),
   .input_span_select(input_span_select),
   .channel_sequence(channel_sequence), .control_loaded(control_loaded),
   .range_loaded(range_loaded), .sequence_loaded(sequence_loaded),
   .result_code(result_code), .result_valid(result_valid));

/* verification/host_link.sv */
// host model driving the serial link
`timescale 1ns/1ns
module host_link (
   output logic sclk,
   output logic cs_n,
   output logic sdi
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi  = 1'b0;
   end
   // one frame msb first; fewer than 16 edges aborts it
   task automatic send(input logic [15:0] w, input int n);
      cs_n = 1'b0;
      for (int i = 15; i > 15 - n; i--) begin
         sdi = w[i];
         #6 sclk = 1'b1;
         #6 sclk = 1'b0;
      end
      sdi = ~sdi; // released line shows no stale bit
      #6 cs_n = 1'b1;
   endtask
endmodule

/* verification/tb.sv */
// self-checking bench for the serial register write decoder
`timescale 1ns/1ns
module tb;
   logic        sys_clk, rst, conv_valid, coding;
   logic [12:0] conv_result, result_code;
   logic [11:0] conversion_control;
   logic [7:0]  input_span_select;
   logic [3:0]  channel_sequence;
   logic        control_loaded, range_loaded, sequence_loaded, result_valid;
   logic [15:0] note_q[$];
   logic [15:0] w;
   wire         sclk, cs_n, sdi;
   int          fail_count, cmp_count, seed;
   adc_serial_register_write_decoder u_dut (.sys_clk(sys_clk), .rst(rst),
      .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .conv_result(conv_result),
      .conv_valid(conv_valid), .conversion_control(conversion_control),
      .input_span_select(input_span_select),
      .channel_sequence(channel_sequence), .control_loaded(control_loaded),
      .range_loaded(range_loaded), .sequence_loaded(sequence_loaded),
      .result_code(result_code), .result_valid(result_valid));
   host_link u_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi));
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // compare one result with its note
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [15:0] next_note();
      return (note_q.size() > 0) ? note_q.pop_front() : 16'hFFFF;
   endfunction
   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // send a frame and note what it should load
   task automatic frame(input logic [15:0] f, input int n);
      u_host.send(f, n);
      if (n == 16) begin
         case (f[15:13])
            3'h4: begin
               note_q.push_back({4'h1, f[12:1]});
               coding = f[5];
            end
            3'h5: note_q.push_back({8'h02, f[12:5]});
            3'h7: note_q.push_back({12'h003, f[12:9]});
            default: ;
         endcase
      end
      repeat (10) @(posedge sys_clk);
   endtask
   // one converter result, back to back with the next
   task automatic conv(input logic [12:0] v);
      conv_result = v;
      conv_valid  = 1'b1;
      note_q.push_back({3'h4, v[12] ^ coding, v[11:0]});
      @(posedge sys_clk);
      #1;
   endtask
   // watch the outputs and take the oldest note
   always @(posedge sys_clk) begin
      if (control_loaded === 1'b1)
         check("control", {4'h1, conversion_control}, next_note());
      if (range_loaded === 1'b1)
         check("range", {8'h02, input_span_select}, next_note());
      if (sequence_loaded === 1'b1)
         check("sequence", {12'h003, channel_sequence}, next_note());
      if (result_valid === 1'b1)
         check("result", {3'h4, result_code}, next_note());
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      test_done();
   end
   initial begin
      seed = 32'hA9306518;
      rst = 1'b1;
      conv_valid = 1'b0;
      conv_result = 13'h0000;
      coding = 1'b0;
      fail_count = 0;
      cmp_count = 0;
      repeat (5) @(posedge sys_clk);
      #1 rst = 1'b0;
      repeat (2) @(posedge sys_clk);
      for (int h = 0; h < 8; h++)
         frame({h[2:0], 13'($random(seed))}, 16);
      $display("test headers done");
      frame(16'h8AAA, 10);
      $display("test abort done");
      for (int c = 0; c < 2; c++) begin
         w = 16'($random(seed));
         w[15:13] = 3'h4;
         w[5] = c[0];
         frame(w, 16);
         @(posedge sys_clk);
         #1;
         conv(13'h1000);
         conv(13'h0FFF);
         conv(13'($random(seed)));
         conv_valid = 1'b0;
         repeat (4) @(posedge sys_clk);
      end
      $display("test coding done");
      check("queue", 16'(note_q.size()), 16'h0000);
      test_done();
   end
endmodule
